// File: data_eeprom_access_control.sv
// indirect access control for the 128-byte data eeprom, axi4-lite register slave.
// assumes reset pins and the protect strap come from outside the clock domain;
// the programming port is driven by logic on clk.
`timescale 1ns/1ns
`include "nv_access_defines.svh"

module data_eeprom_access_control #(
  parameter int unsigned STORE_CYC =
    (`STORE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS  // store time in cycles
) (
  // clock and power-up reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // axi4-lite write address and data
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // other reset sources, asynchronous pins
  input  wire logic                 external_reset_pin,
  input  wire logic                 watchdog_timeout,
  input  wire logic                 brownout_detect,
  // data protection strap, high when protected
  input  wire logic                 data_protect,
  // external programming port
  input  wire logic                 prog_req,
  input  wire logic                 prog_write,
  input  wire logic [`ARRAY_AW-1:0] prog_addr,
  input  wire nv_access_pkg::byte_t prog_wdata,
  output nv_access_pkg::byte_t      prog_rdata,
  output logic                      prog_ack,
  output logic                      prog_denied
);
  import nv_access_pkg::*;

  // synchronisers for the four asynchronous inputs
  logic [3:0] pin_meta_q;                 // first stage, read only by second
  logic [3:0] pin_sync_q;                 // second stage
  logic       other_rst;                  // any non power-up reset active
  logic       protect;                    // synchronised protection strap

  // axi state
  logic        aw_held_q;                 // write address captured
  logic [11:0] aw_addr_q;                 // captured write address
  logic        w_held_q;                  // write data captured
  logic [7:0]  w_data_q;                  // captured low byte
  logic        w_lane0_q;                 // low byte lane enabled
  logic        bvalid_q;                  // write response pending
  logic [1:0]  bresp_q;                   // write response code
  logic        rvalid_q;                  // read response pending
  logic [31:0] rdata_q;                   // read response data
  logic [1:0]  rresp_q;                   // read response code
  logic        wr_fire;                   // register write takes effect

  // register file
  byte_t        data_q;                   // nv_byte_reg
  byte_t        index_q;                  // nv_index_reg
  logic         permit_q;                 // store_permit
  logic         abort_q;                  // store_abort_flag
  logic         done_q;                   // store_done_flag
  logic         rd_trig_q;                // read trigger
  logic         rd_load_q;                // array read data lands next edge

  // store engine
  store_state_t st_q;                     // store sequence state
  logic [19:0]  timer_q;                  // self-timer
  logic [6:0]   st_addr_q;                // captured location
  byte_t        st_data_q;                // captured byte
  logic         st_prog_q;                // store belongs to programmer
  key_state_t   key_q;                    // unlock progress
  logic [4:0]   key_cnt_q;                // unlock window counter

  // programming port
  logic         prog_load_q;              // programmer read lands next edge
  logic         prog_ack_q;               // programmer answer pulse
  logic         prog_denied_q;            // programmer refused pulse
  byte_t        prog_rdata_q;             // programmer read data

  // decoded strobes
  logic  wr_data, wr_index, wr_ctl, wr_key, wr_flag;
  logic  store_go, store_done, cpu_rd_fire, prog_take;
  logic  mem_we, mem_re;
  logic [6:0] mem_waddr, mem_raddr;
  byte_t mem_wdata, mem_rdata;

  // two-flop synchroniser on the pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= {data_protect, brownout_detect, watchdog_timeout, external_reset_pin};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign other_rst = |pin_sync_q[2:0];
  assign protect   = pin_sync_q[3];

  // axi handshakes: address and data accepted independently
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;

  // capture write address and data, release both when the write fires
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_held_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_held_q <= 1'b0;
      end else if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (wr_fire) begin
        w_held_q <= 1'b0;
      end else if (s_axi_wvalid && !w_held_q) begin
        w_held_q  <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
    end
  end

  // address decode; array never appears in the map
  always_comb begin
    wr_data  = wr_fire && w_lane0_q && (aw_addr_q == `IDX2ADDR(`DATA_REG_IDX));
    wr_index = wr_fire && w_lane0_q && (aw_addr_q == `IDX2ADDR(`INDEX_REG_IDX));
    wr_ctl   = wr_fire && w_lane0_q && (aw_addr_q == `IDX2ADDR(`CONTROL_REG_IDX));
    wr_key   = wr_fire && w_lane0_q && (aw_addr_q == `IDX2ADDR(`UNLOCK_PORT_IDX));
    wr_flag  = wr_fire && w_lane0_q && (aw_addr_q == `IDX2ADDR(`FLAG_REG_IDX));
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      case (aw_addr_q)
        `IDX2ADDR(`DATA_REG_IDX), `IDX2ADDR(`INDEX_REG_IDX),
        `IDX2ADDR(`CONTROL_REG_IDX), `IDX2ADDR(`UNLOCK_PORT_IDX),
        `IDX2ADDR(`FLAG_REG_IDX): bresp_q <= `RESP_OKAY;
        default:                  bresp_q <= `RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read response, one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      case (s_axi_araddr)
        `IDX2ADDR(`DATA_REG_IDX):    rdata_q[7:0] <= data_q;
        `IDX2ADDR(`INDEX_REG_IDX):   rdata_q[7:0] <= index_q;
        // upper nibble unimplemented
        `IDX2ADDR(`CONTROL_REG_IDX): rdata_q[7:0] <= {4'h0, abort_q, permit_q,
                                                     (st_q != ST_IDLE) && !st_prog_q,
                                                     rd_trig_q};
        `IDX2ADDR(`UNLOCK_PORT_IDX): rdata_q[7:0] <= 8'h00;
        `IDX2ADDR(`FLAG_REG_IDX):    rdata_q[`FLAG_DONE_BIT] <= done_q;
        default:                     rresp_q <= `RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // unlock key tracker; any other write or the window running out resets it
  always_ff @(posedge clk) begin
    if (!resetn || other_rst) begin
      key_q     <= KEY_NONE;
      key_cnt_q <= 5'h00;
    end else if (wr_key && w_data_q == `KEY_FIRST) begin
      key_q     <= KEY_GOT_1;
      key_cnt_q <= 5'h00;
    end else if (wr_key && w_data_q == `KEY_SECOND && key_q == KEY_GOT_1) begin
      key_q     <= KEY_GOT_2;
      key_cnt_q <= 5'h00;
    end else if (wr_fire) begin
      key_q <= KEY_NONE;
    end else if (key_q != KEY_NONE) begin
      if (key_cnt_q == 5'(`UNLOCK_WINDOW_CYC - 1)) begin
        key_q <= KEY_NONE; // too slow, sequence broken
      end else begin
        key_cnt_q <= key_cnt_q + 5'h01;
      end
    end
  end

  // store start needs key, permit already set and an idle engine
  assign store_go = wr_ctl && w_data_q[`CTL_STORE_BIT] && key_q == KEY_GOT_2
                    && permit_q && st_q == ST_IDLE && !other_rst;
  assign store_done = st_q == ST_PROG && timer_q == 20'(STORE_CYC - 1);

  // read fires on the trigger write, or once the store has finished
  assign cpu_rd_fire = !other_rst && st_q == ST_IDLE && !store_go && !rd_load_q
                       && ((wr_ctl && w_data_q[`CTL_READ_BIT]) || rd_trig_q);
  assign prog_take = prog_req && !other_rst && st_q == ST_IDLE && !store_go
                     && !cpu_rd_fire && !rd_trig_q && !prog_load_q
                     && !prog_ack_q && !prog_denied_q;

  // store engine: erase one cycle, then program when the timer runs out
  always_ff @(posedge clk) begin
    if (!resetn || other_rst) begin
      st_q      <= ST_IDLE;
      timer_q   <= 20'h00000;
      st_addr_q <= 7'h00;
      st_data_q <= 8'h00;
      st_prog_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          timer_q <= 20'h00000;
          if (store_go) begin
            st_q      <= ST_ERASE;
            st_addr_q <= index_q[6:0];
            st_data_q <= data_q;
            st_prog_q <= 1'b0;
          end else if (prog_take && prog_write && !protect) begin
            st_q      <= ST_ERASE;
            st_addr_q <= prog_addr;
            st_data_q <= prog_wdata;
            st_prog_q <= 1'b1;
          end
        end
        ST_ERASE: begin
          st_q <= ST_PROG; // location erased this cycle
        end
        ST_PROG: begin
          if (store_done) begin
            st_q <= ST_IDLE;
          end else begin
            timer_q <= timer_q + 20'h00001;
          end
        end
      endcase
    end
  end

  // array ports; the programmer is refused under protection
  always_comb begin
    mem_we    = (st_q == ST_ERASE) || store_done;
    mem_waddr = st_addr_q;
    mem_wdata = (st_q == ST_ERASE) ? `ERASED_BYTE : st_data_q;
    mem_re    = cpu_rd_fire || (prog_take && !prog_write && !protect);
    mem_raddr = cpu_rd_fire ? index_q[6:0] : prog_addr;
  end

  nv_array_mem u_array (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .re    (mem_re),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // read trigger: set-only from software, cleared when data lands
  always_ff @(posedge clk) begin
    if (!resetn || other_rst) begin
      rd_trig_q <= 1'b0;
      rd_load_q <= 1'b0;
    end else begin
      rd_load_q <= cpu_rd_fire;
      if (wr_ctl && w_data_q[`CTL_READ_BIT]) begin
        rd_trig_q <= 1'b1; // a new request outlives the clear of the last one
      end else if (rd_load_q) begin
        rd_trig_q <= 1'b0;
      end
    end
  end

  // data register: array read wins over a software write
  always_ff @(posedge clk) begin
    if (!resetn || other_rst) begin
      data_q <= `DATA_RESET;
    end else if (rd_load_q) begin
      data_q <= mem_rdata;
    end else if (wr_data) begin
      data_q <= w_data_q;
    end
  end

  // index register; bit 7 stored but never decoded
  always_ff @(posedge clk) begin
    if (!resetn || other_rst) begin
      index_q <= `INDEX_RESET;
    end else if (wr_index) begin
      index_q <= w_data_q;
    end
  end

  // permit survives other resets; only power-up or software clear it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      permit_q <= 1'b0;
    end else if (wr_ctl) begin
      permit_q <= w_data_q[`CTL_PERMIT_BIT];
    end
  end

  // abort flag: interruption sets, software writes, clean finish clears
  always_ff @(posedge clk) begin
    if (!resetn) begin
      abort_q <= 1'b0;
    end else if (other_rst && st_q != ST_IDLE) begin
      abort_q <= 1'b1;
    end else if (wr_ctl) begin
      abort_q <= w_data_q[`CTL_ABORT_BIT];
    end else if (store_done) begin
      abort_q <= 1'b0;
    end
  end

  // done flag: completion set beats a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn || other_rst) begin
      done_q <= 1'b0;
    end else if (store_done) begin
      done_q <= 1'b1;
    end else if (wr_flag && !w_data_q[`FLAG_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // programming port answers: read data, acknowledge, refusal
  always_ff @(posedge clk) begin
    if (!resetn || other_rst) begin
      prog_load_q   <= 1'b0;
      prog_ack_q    <= 1'b0;
      prog_denied_q <= 1'b0;
      prog_rdata_q  <= 8'h00;
    end else begin
      prog_load_q   <= prog_take && !prog_write && !protect;
      prog_denied_q <= prog_take && protect;
      prog_ack_q    <= prog_load_q || (store_done && st_prog_q);
      if (prog_load_q) begin
        prog_rdata_q <= mem_rdata;
      end
    end
  end
  assign prog_rdata  = prog_rdata_q;
  assign prog_ack    = prog_ack_q;
  assign prog_denied = prog_denied_q;

endmodule // data_eeprom_access_control

// File: nv_access_defines.svh
// constants of the data eeprom access block: register indices, byte addresses,
// field positions, reset values and timing counts.
// assumes it is included by its bare name from every file that needs it.
`ifndef NV_ACCESS_DEFINES_SVH
`define NV_ACCESS_DEFINES_SVH

// register indices; byte address is four times the index
`define FLAG_REG_IDX     8'h0c
`define DATA_REG_IDX     8'h9a
`define INDEX_REG_IDX    8'h9b
`define CONTROL_REG_IDX  8'h9c
`define UNLOCK_PORT_IDX  8'h9d
`define IDX2ADDR(i)      ({2'b00, (i), 2'b00})

// array geometry
`define ARRAY_DEPTH      128
`define ARRAY_AW         7
`define ERASED_BYTE      8'hff

// control register fields
`define CTL_READ_BIT     0
`define CTL_STORE_BIT    1
`define CTL_PERMIT_BIT   2
`define CTL_ABORT_BIT    3
// peripheral flag register field
`define FLAG_DONE_BIT    7

// reset values
`define DATA_RESET       8'h00
`define INDEX_RESET      8'h00

// unlock key bytes
`define KEY_FIRST        8'h55
`define KEY_SECOND       8'haa

// timing
`define CLK_PERIOD_NS    8
`define STORE_TIME_NS    5000000
`define UNLOCK_WINDOW_CYC 16

// axi responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// File: nv_access_pkg.sv
// types shared by the data eeprom access block.
// assumes nv_access_defines.svh is available for constants.
package nv_access_pkg;

  // self-timed store sequence
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b10
  } store_state_t;

  // progress through the unlock key sequence
  typedef enum logic [1:0] {
    KEY_NONE  = 2'b00,
    KEY_GOT_1 = 2'b01,
    KEY_GOT_2 = 2'b10
  } key_state_t;

  typedef logic [7:0] byte_t;

endpackage

// File: nv_array_mem.sv
// the 128-byte data array: one write port, one read port with registered data.
// assumes a single clock; no reset on the storage itself.
`timescale 1ns/1ns
`include "nv_access_defines.svh"

module nv_array_mem (
  // clock
  input  wire logic                   clk,
  // write port
  input  wire logic                   we,
  input  wire logic [`ARRAY_AW-1:0]   waddr,
  input  wire logic [7:0]             wdata,
  // read port
  input  wire logic                   re,
  input  wire logic [`ARRAY_AW-1:0]   raddr,
  output logic      [7:0]             rdata
);

  logic [7:0] cells [`ARRAY_DEPTH];  // storage cells

  // write a cell; erase and program both pass here
  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  // read data held in a register until the next read
  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= cells[raddr];
    end
  end

endmodule // nv_array_mem

// File: data_eeprom_access_control_monitor.sv
// port assertions for the data eeprom access block.
// assumes bind onto data_eeprom_access_control; one clock, sync low reset.
`timescale 1ns/1ns
`include "nv_access_defines.svh"
module data_eeprom_access_control_monitor #(
  parameter int unsigned STORE_CYC = 8  // store length, unused here
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 resetn,
  // axi read and write answers
  input wire logic [11:0]          s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  // programming port
  input wire logic                 data_protect,
  input wire logic                 prog_ack,
  input wire logic                 prog_denied,
  input wire nv_access_pkg::byte_t prog_rdata
);
  import nv_access_pkg::*;
  logic [11:0] ar_q;    // address of the read being answered
  logic        mapped;  // that address hits a register
  assign mapped = ar_q inside {12'h030, 12'h268, 12'h26c, 12'h270, 12'h274};
  // remember the read address at its handshake
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  chk_r_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_resp: assert property (
    s_axi_rvalid |-> s_axi_rresp == (mapped ? `RESP_OKAY : `RESP_SLVERR))
    else $error("read response code wrong");
  chk_byte_wide: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_ctl_upper: assert property (
    s_axi_rvalid && ar_q == 12'h270 |-> s_axi_rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  chk_key_zero: assert property (
    s_axi_rvalid && ar_q == 12'h274 |-> s_axi_rdata == 32'h0)
    else $error("unlock port read not zero");
  chk_deny_cause: assert property (
    prog_denied |-> $past(data_protect, 3) && !prog_ack)
    else $error("programmer denied while unprotected");
  chk_prog_data: assert property (
    $changed(prog_rdata) |-> prog_ack)
    else $error("programmer data moved without answer");
endmodule // data_eeprom_access_control_monitor

bind data_eeprom_access_control data_eeprom_access_control_monitor #(
  .STORE_CYC(STORE_CYC)
) mon (.clk(clk), .resetn(resetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .data_protect(data_protect), .prog_ack(prog_ack), .prog_denied(prog_denied),
  .prog_rdata(prog_rdata));

// File: tb_data_eeprom_access_control.sv
// self-checking bench for the data eeprom access block over axi4-lite.
// assumes the monitor file is compiled with it; store time is shortened.
`timescale 1ns/1ns
`include "nv_access_defines.svh"
module tb_data_eeprom_access_control;
  import nv_access_pkg::*;
  localparam int unsigned SC = 40;  // long enough to act during a store
  localparam logic [11:0] A_FLG = `IDX2ADDR(`FLAG_REG_IDX);
  localparam logic [11:0] A_DAT = `IDX2ADDR(`DATA_REG_IDX);
  localparam logic [11:0] A_IDX = `IDX2ADDR(`INDEX_REG_IDX);
  localparam logic [11:0] A_CTL = `IDX2ADDR(`CONTROL_REG_IDX);
  localparam logic [11:0] A_KEY = `IDX2ADDR(`UNLOCK_PORT_IDX);
  logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, external_reset_pin, watchdog_timeout, brownout_detect;
  logic data_protect, prog_req, prog_write, prog_ack, prog_denied;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  prog_addr;
  byte_t       prog_wdata, prog_rdata;
  int          bad_count, n_compared;
  data_eeprom_access_control #(.STORE_CYC(SC)) uut (.clk, .resetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .external_reset_pin, .watchdog_timeout, .brownout_detect,
    .data_protect, .prog_req, .prog_write, .prog_addr, .prog_wdata, .prog_rdata,
    .prog_ack, .prog_denied);
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus write; handshakes judged at the rising edge, released right after it;
  // late keeps bready low until bvalid shows, so the answer must stand
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er = `RESP_OKAY, input logic late = 1'b0);
    logic tb;
    logic [1:0] r;
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !late;
    do begin
      @(posedge clk);
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !tb) s_axi_bready <= 1'b1;
      n++;
    end while (tb !== 1'b1 && n < 50);
    cmp("bvalid", 32'h1, {31'h0, tb});
    cmp("bresp", {30'h0, er}, {30'h0, r});
  endtask
  // bus read returning data and response; late as for writes
  task automatic rdv(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r,
                     input logic late = 1'b0);
    logic tr;
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !late;
    do begin
      @(posedge clk);
      tr = s_axi_rvalid && s_axi_rready;
      v = s_axi_rdata;
      r = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !tr) s_axi_rready <= 1'b1;
      n++;
    end while (tr !== 1'b1 && n < 50);
    cmp("rvalid", 32'h1, {31'h0, tr});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er = `RESP_OKAY, input logic late = 1'b0);
    logic [31:0] v;
    logic [1:0] r;
    rdv(a, v, r, late);
    cmp("rresp", {30'h0, er}, {30'h0, r});
    cmp("rdata", e, v);
  endtask
  // poll the busy bit; bounded so a stuck store cannot hang
  task automatic wait_idle;
    logic [31:0] v;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rdv(A_CTL, v, r);
      n++;
    end while (v[1] !== 1'b0 && n < 60);
  endtask
  // c adds extra control bits to the trigger write
  task automatic store(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c = 8'h00);
    wr(A_CTL, 8'h04);
    wr(A_IDX, a);
    wr(A_DAT, d);
    wr(A_KEY, `KEY_FIRST);
    wr(A_KEY, `KEY_SECOND);
    wr(A_CTL, 8'h06 | c);
  endtask
  // programmer access, w high for a write; dn tells whether a refusal is expected
  task automatic prog_op(input logic w, input logic [6:0] a, input logic dn,
                         input logic [7:0] e);
    logic ak, dd;
    byte_t pd;
    int n;
    n = 0;
    prog_addr <= a;
    prog_write <= w;
    prog_wdata <= e;
    prog_req <= 1'b1;
    do begin
      @(posedge clk);
      ak = prog_ack;
      dd = prog_denied;
      pd = prog_rdata;
      n++;
    end while (ak !== 1'b1 && dd !== 1'b1 && n < 50);
    prog_req <= 1'b0;
    cmp("prog_ack", {31'h0, !dn}, {31'h0, ak});
    cmp("prog_denied", {31'h0, dn}, {31'h0, dd});
    if (!dn && !w) cmp("prog_rdata", {24'h0, e}, {24'h0, pd});
  endtask
  task automatic t_reset;
    rd(A_DAT, 32'h0);
    rd(A_IDX, 32'h0);
    rd(A_CTL, 32'h0);
    rd(A_KEY, 32'h0);
    rd(A_FLG, 32'h0);
  endtask
  task automatic t_regs;
    wr(A_CTL, 8'hf0);
    rd(A_CTL, 32'h0);
    wr(A_KEY, 8'h5a);
    rd(A_KEY, 32'h0);
    wr(12'h100, 8'h00, `RESP_SLVERR);
    rd(12'h100, 32'h0, `RESP_SLVERR);
    wr(A_DAT, 8'hc3, `RESP_OKAY, 1'b1);
    rd(A_DAT, 32'hc3, `RESP_OKAY, 1'b1);
    wr(A_KEY, `KEY_FIRST);
    wr(A_KEY, `KEY_SECOND);
    wr(A_CTL, 8'h02);
    rd(A_CTL, 32'h0);
  endtask
  task automatic t_store;
    store(8'h85, 8'h3c);
    rd(A_CTL, 32'h06);
    wr(A_CTL, 8'h00);
    rd(A_CTL, 32'h02);
    wait_idle();
    rd(A_CTL, 32'h00);
    rd(A_FLG, 32'h80);
    wr(A_FLG, 8'h00);
    rd(A_FLG, 32'h00);
    wr(A_IDX, 8'h05);
    wr(A_CTL, 8'h01);
    rd(A_DAT, 32'h3c);
    rd(A_CTL, 32'h00);
  endtask
  // broken, reversed and late unlock sequences must not start a store
  task automatic t_break;
    wr(A_CTL, 8'h04);
    wr(A_KEY, `KEY_FIRST);
    wr(A_DAT, 8'h11);
    wr(A_KEY, `KEY_SECOND);
    wr(A_CTL, 8'h06);
    rd(A_CTL, 32'h04);
    wr(A_KEY, `KEY_SECOND);
    wr(A_KEY, `KEY_FIRST);
    wr(A_CTL, 8'h06);
    rd(A_CTL, 32'h04);
    wr(A_KEY, `KEY_FIRST);
    wr(A_KEY, `KEY_SECOND);
    repeat (`UNLOCK_WINDOW_CYC + 4) @(posedge clk);
    wr(A_CTL, 8'h06);
    rd(A_CTL, 32'h04);
  endtask
  // each of the three reset pins in turn cuts a running store short
  task automatic t_abort;
    for (int k = 0; k < 3; k++) begin
      store(8'h30, 8'h99);
      {brownout_detect, watchdog_timeout, external_reset_pin} <= 3'b001 << k;
      repeat (4) @(posedge clk);
      {brownout_detect, watchdog_timeout, external_reset_pin} <= 3'b000;
      repeat (4) @(posedge clk);
      rd(A_CTL, 32'h0c);
      rd(A_DAT, 32'h00);
      rd(A_IDX, 32'h00);
    end
  endtask
  // a read asked for mid-store waits; the store keeps its captured values
  task automatic t_busy;
    store(8'h20, 8'ha5, 8'h08); // abort bit raised by software, cleared on finish
    wait_idle();
    rd(A_CTL, 32'h04);
    store(8'h10, 8'h3c);
    wr(A_IDX, 8'h20);
    wr(A_CTL, 8'h05);
    rd(A_DAT, 32'h3c);
    wait_idle();
    rd(A_DAT, 32'ha5);
    wr(A_IDX, 8'h10);
    wr(A_CTL, 8'h05);
    rd(A_DAT, 32'h3c);
  endtask
  task automatic t_prog;
    prog_op(1'b1, 7'h21, 1'b0, 8'h5e);
    @(posedge clk);
    prog_op(1'b0, 7'h21, 1'b0, 8'h5e);
    data_protect <= 1'b1;
    repeat (4) @(posedge clk);
    prog_op(1'b0, 7'h20, 1'b1, 8'h00);
    wr(A_IDX, 8'h20);
    wr(A_CTL, 8'h05);
    rd(A_DAT, 32'ha5);
  endtask
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog: the whole run needs a few hundred cycles
  initial begin
    #(8 * 20000);
    bad_count++;
    test_done();
  end
  // main sequence
  initial begin
    bad_count = 0;
    n_compared = 0;
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {external_reset_pin, watchdog_timeout, brownout_detect, data_protect} = 4'h0;
    {prog_req, prog_write} = 2'b00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    prog_addr = 7'h00;
    prog_wdata = 8'h00;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_store();
    t_break();
    t_abort();
    t_busy();
    t_prog();
    test_done();
  end
endmodule // tb_data_eeprom_access_control
